// *** aeid_master.sv ***
// Master end: bus sequencer for clear, assign, write and read
`timescale 1ns/1ns
`include "aeid_defs.svh"
module aeid_master #(
  parameter int QUARTER = `AEID_QUARTER_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Command port
  input wire logic i_req,
  input wire aeid_pkg::aeid_op_t i_op,
  input wire logic [7:0] i_id,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_detect,
  // Results
  output logic o_busy,
  output logic o_done,
  output logic o_ack,
  output logic [7:0] o_rdata,
  output logic [7:0] o_last_id,
  output logic [7:0] o_stamp_addr,
  output aeid_pkg::aeid_card_t o_card,
  // Two-wire bus
  aeid_bus_if.master bus
);

  aeid_pkg::aeid_mreg_t r;
  aeid_pkg::aeid_mreg_t n;
  aeid_pkg::aeid_step_t cur;

  function automatic aeid_pkg::aeid_step_t mk(input aeid_pkg::aeid_kind_t k,
                                              input logic [7:0] v, input logic a);
    mk.kind = k;
    mk.val = v;
    mk.ack = a;
  endfunction

  // ----------------------------------------------------------------
  // Step tables of each operation
  // ----------------------------------------------------------------
  function automatic aeid_pkg::aeid_step_t step_of(input aeid_pkg::aeid_mreg_t m);
    logic [7:0] wr;
    logic [7:0] rd;
    wr = `AEID_CMD_WRITE | (m.det ? `AEID_DET_MASK : 8'h00); // [RL6] [RL11]
    rd = `AEID_CMD_READ | (m.det ? `AEID_DET_MASK : 8'h00);
    step_of = mk(aeid_pkg::S_END, 8'h00, 1'b0);
    case (m.op)
      aeid_pkg::OP_CLEAR: begin
        case (m.step)
          4'h0: step_of = mk(aeid_pkg::S_START, 8'h00, 1'b0);
          4'h1: step_of = mk(aeid_pkg::S_TX, `AEID_CMD_CLEAR, 1'b0);
          4'h2: step_of = mk(aeid_pkg::S_TX, `AEID_CLEAR_DUMMY, 1'b0); // [RL5]
          4'h3: step_of = mk(aeid_pkg::S_STOP, 8'h00, 1'b0); // [RL5]
          default: ;
        endcase
      end
      aeid_pkg::OP_ASSIGN: begin
        case (m.step)
          4'h0: step_of = mk(aeid_pkg::S_START, 8'h00, 1'b0);
          4'h1: step_of = mk(aeid_pkg::S_TX, `AEID_CMD_ASSIGN, 1'b0);
          4'h2: step_of = mk(aeid_pkg::S_TX, m.id, 1'b0);
          4'h9: step_of = mk(aeid_pkg::S_STOP, 8'h00, 1'b0); // [RL2]
          4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: ;
          default: step_of = mk(aeid_pkg::S_RX, 8'h00, m.step != 4'h8); // [RL2]
        endcase
      end
      aeid_pkg::OP_WRITE: begin
        case (m.step)
          4'h0, 4'h6: step_of = mk(aeid_pkg::S_START, 8'h00, 1'b0);
          4'h1, 4'h7: step_of = mk(aeid_pkg::S_TX, wr, 1'b0); // [RL8]
          4'h2, 4'h8: step_of = mk(aeid_pkg::S_TX, m.id, 1'b0); // [RL8]
          4'h3: step_of = mk(aeid_pkg::S_TX, m.addr, 1'b0); // [RL8]
          4'h4: step_of = mk(aeid_pkg::S_TX, m.data, 1'b0); // [RL8]
          4'h5, 4'h9: step_of = mk(aeid_pkg::S_STOP, 8'h00, 1'b0); // [RL9] [RL12]
          default: ;
        endcase
      end
      default: begin
        case (m.step)
          4'h0, 4'h4: step_of = mk(aeid_pkg::S_START, 8'h00, 1'b0); // [RL13]
          4'h1: step_of = mk(aeid_pkg::S_TX, wr, 1'b0);
          4'h2, 4'h6: step_of = mk(aeid_pkg::S_TX, m.id, 1'b0);
          4'h3: step_of = mk(aeid_pkg::S_TX, m.addr, 1'b0);
          4'h5: step_of = mk(aeid_pkg::S_TX, rd, 1'b0); // [RL13]
          4'h7: step_of = mk(aeid_pkg::S_RX, 8'h00, 1'b0); // [RL13]
          4'h8: step_of = mk(aeid_pkg::S_STOP, 8'h00, 1'b0);
          default: ;
        endcase
      end
    endcase
  endfunction

  // Load the pins and state for the step now due
  function automatic aeid_pkg::aeid_mreg_t enter(input aeid_pkg::aeid_mreg_t m);
    aeid_pkg::aeid_step_t k;
    k = step_of(m);
    enter = m;
    enter.q = 2'h0;
    enter.div = 16'h0000;
    enter.bitcnt = 4'h0;
    enter.scl_oe = 1'b1;
    case (k.kind)
      aeid_pkg::S_START: begin
        enter.st = aeid_pkg::M_START;
        enter.sda_oe = 1'b0;
      end
      aeid_pkg::S_TX: begin
        enter.st = aeid_pkg::M_BIT;
        enter.tx = {k.val, 1'b1};
        enter.sda_oe = !k.val[7];
      end
      aeid_pkg::S_RX: begin
        enter.st = aeid_pkg::M_BIT;
        enter.tx = {8'hff, !k.ack};
        enter.sda_oe = 1'b0;
      end
      aeid_pkg::S_STOP: begin
        enter.st = aeid_pkg::M_STOP;
        enter.sda_oe = 1'b1;
      end
      default: begin
        enter.st = aeid_pkg::M_IDLE;
        enter.scl_oe = 1'b0;
        enter.sda_oe = 1'b0;
        enter.busy = 1'b0;
        enter.done = 1'b1;
        // Remember the last ID handed out; a clear starts over
        if (m.op == aeid_pkg::OP_ASSIGN && m.found) begin
          enter.last_id = m.id; // [RL16]
        end
        if (m.op == aeid_pkg::OP_CLEAR) begin
          enter.last_id = 8'h00;
        end
      end
    endcase
  endfunction

  assign cur = step_of(r);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (r.st == aeid_pkg::M_IDLE) begin
      if (i_req) begin
        n.op = i_op;
        n.id = (i_op == aeid_pkg::OP_ASSIGN) ? r.last_id + 8'h01 : i_id; // [RL16]
        n.addr = i_addr;
        n.data = i_data;
        n.det = i_detect; // [RL11]
        n.found = 1'b1;
        n.busy = 1'b1;
        n.step = 4'h0;
        n = enter(n);
      end
    end else if (r.div != 16'(QUARTER - 1)) begin
      n.div = r.div + 16'h0001;
    end else begin
      n.div = 16'h0000;
      n.q = r.q + 2'h1;
      // Quarter-bit phases: data set, clock high, sample, clock low
      case (r.st)
        aeid_pkg::M_START: begin
          case (r.q)
            2'h0: n.scl_oe = 1'b0;
            2'h1: n.sda_oe = 1'b1;
            2'h2: n.scl_oe = 1'b1;
            default: ;
          endcase
        end
        aeid_pkg::M_BIT: begin
          case (r.q)
            2'h0: n.scl_oe = 1'b0;
            2'h1: begin
              if (r.bitcnt != 4'h8) begin
                n.rx = {r.rx[6:0], bus.sda};
              end else begin
                n.ack = !bus.sda;
              end
            end
            2'h2: n.scl_oe = 1'b1;
            default: ;
          endcase
        end
        aeid_pkg::M_STOP: begin
          case (r.q)
            2'h0: n.scl_oe = 1'b0;
            2'h1: n.sda_oe = 1'b0;
            default: ;
          endcase
        end
        default: ;
      endcase
      if (r.q == 2'h3) begin
        if (r.st == aeid_pkg::M_BIT && r.bitcnt != 4'h8) begin
          n.bitcnt = r.bitcnt + 4'h1;
          n.tx = {r.tx[7:0], 1'b1};
          n.sda_oe = !r.tx[7];
        end else begin
          n.step = r.step + 4'h1;
          if (cur.kind == aeid_pkg::S_RX) begin
            n.rdata = r.rx;
            // Size and type locations feed the stamp address and card class
            if (r.op == aeid_pkg::OP_READ && r.addr == `AEID_LOC_SIZE) begin
              n.stamp_addr = r.rx - `AEID_STAMP_BYTES; // [RL14] [RL15]
            end
            if (r.op == aeid_pkg::OP_READ && r.addr == `AEID_LOC_TYPE) begin
              case (r.rx) // [RL14] [RL17]
                `AEID_TYPE_MEMORY: n.card = aeid_pkg::CARD_MEMORY;
                `AEID_TYPE_IO: n.card = aeid_pkg::CARD_IO;
                `AEID_TYPE_DISPLAY: n.card = aeid_pkg::CARD_DISPLAY;
                default: n.card = aeid_pkg::CARD_UNKNOWN;
              endcase
            end
          end
          if (cur.kind == aeid_pkg::S_TX && !r.ack) begin
            if (r.op == aeid_pkg::OP_WRITE && r.step == 4'h8) begin
              n.step = 4'h6; // [RL10]
            end else begin
              n.found = 1'b0;
              if (r.op == aeid_pkg::OP_ASSIGN && r.step == 4'h2) begin
                n.step = 4'h9; // [RL3]
              end
            end
          end
          n = enter(n);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = r.scl_oe;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = r.sda_oe;
  assign o_busy = r.busy;
  assign o_done = r.done;
  assign o_ack = r.found;
  assign o_rdata = r.rdata;
  assign o_last_id = r.last_id;
  assign o_stamp_addr = r.stamp_addr;
  assign o_card = r.card;

endmodule

// *** aeid_defs.svh ***
// Constants of the addressable EEPROM ID link
//
// How it works
// RL1 - Only unassigned devices acknowledge assign command
// RL2 - Serial read latches the offered ID
// RL3 - Missing acknowledge ends the master's search
// RL4 - Clear command zeroes ID, makes device unassigned
// RL5 - Clear command followed by dummy byte, stop
// RL6 - Command bit three drives detect pin low
// RL7 - Detect pin tells card controller it is assigned
// RL8 - Write: command, ID, address, data, each acknowledged
// RL9 - Stop after data starts internal write
// RL10 - Busy device withholds acknowledge; master repeats poll
// RL11 - Polling keeps the detect bit unchanged
// RL12 - Stop after poll is acknowledged
// RL13 - Read: set pointer, restart, read one byte
// RL14 - Location zero holds size, one holds type
// RL15 - Time stamp goes into last three bytes
// RL16 - Master assigns IDs in sequence, remembers last
// RL17 - Type codes: memory, input/output, display, else unknown
// RL18 - Unassigned device ignores ID-addressed reads and writes
`ifndef AEID_DEFS_SVH
`define AEID_DEFS_SVH

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define AEID_CMD_READ 8'h61
`define AEID_CMD_WRITE 8'h62
`define AEID_CMD_ASSIGN 8'h64
`define AEID_CMD_CLEAR 8'h66
`define AEID_DET_BIT 3
`define AEID_DET_MASK 8'h08
`define AEID_CLEAR_DUMMY 8'h00

// ----------------------------------------------------------------
// Array layout and serial number
// ----------------------------------------------------------------
`define AEID_MEM_BYTES 256
`define AEID_SN_BYTES 3'h6
`define AEID_LOC_SIZE 8'h00
`define AEID_LOC_TYPE 8'h01
`define AEID_STAMP_BYTES 8'h03
`define AEID_TYPE_MEMORY 8'h01
`define AEID_TYPE_IO 8'h02
`define AEID_TYPE_DISPLAY 8'h03

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AEID_CLK_HZ 100000000
`define AEID_SCL_HZ 100000
`define AEID_QUARTER_CYCLES (`AEID_CLK_HZ / (4 * `AEID_SCL_HZ))
`define AEID_WRITE_CYCLES 1000
`define AEID_CNT_W 16

`endif

// *** aeid_pkg.sv ***
// Types shared by both ends of the addressable EEPROM ID link
package aeid_pkg;

  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACKW, D_ACK, D_TX, D_TXACK} aeid_dst_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} aeid_mst_t;
  typedef enum logic [1:0] {OP_CLEAR, OP_ASSIGN, OP_WRITE, OP_READ} aeid_op_t;
  typedef enum logic [2:0] {S_START, S_TX, S_RX, S_STOP, S_END} aeid_kind_t;
  typedef enum logic [1:0] {CARD_UNKNOWN, CARD_MEMORY, CARD_IO, CARD_DISPLAY} aeid_card_t;

  typedef struct packed {
    aeid_kind_t kind;
    logic [7:0] val;
    logic ack;
  } aeid_step_t;

  typedef struct packed {
    aeid_dst_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [2:0] idx;
    logic [7:0] cmd;
    logic det_req;
    logic [2:0] sn_idx;
    logic [7:0] id;
    logic assigned;
    logic [7:0] pend_id;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wr_pend;
    logic busy;
    logic [15:0] cnt;
    logic det_n;
    logic sda_oe;
    logic ack;
    logic scl_q;
    logic sda_q;
  } aeid_dreg_t;

  typedef struct packed {
    aeid_mst_t st;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] bitcnt;
    logic [8:0] tx;
    logic [7:0] rx;
    logic [3:0] step;
    aeid_op_t op;
    logic [7:0] id;
    logic [7:0] addr;
    logic [7:0] data;
    logic det;
    logic ack;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic done;
    logic found;
    logic [7:0] rdata;
    logic [7:0] last_id;
    logic [7:0] stamp_addr;
    aeid_card_t card;
  } aeid_mreg_t;

endpackage

// *** aeid_bus_if.sv ***
// Two-wire bus joining the master end and the device end
`timescale 1ns/1ns
interface aeid_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wired-AND with pull-ups
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport device (output d_sda_o, d_sda_oe, input scl, sda);
endinterface

// *** aeid_device.sv ***
// Device end: ID arbitration, byte access, write cycle and detect pin
`timescale 1ns/1ns
`include "aeid_defs.svh"
module aeid_device #(
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001, // Arbitrary value
  parameter int WRITE_CYCLES = `AEID_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Two-wire bus
  aeid_bus_if.device bus,
  // Card side
  output logic o_card_detect_output_n,
  output logic o_assigned,
  output logic [7:0] o_id,
  output logic o_write_busy
);

  // ----------------------------------------------------------------
  // State and array
  // ----------------------------------------------------------------
  logic [7:0] mem [`AEID_MEM_BYTES];
  aeid_pkg::aeid_dreg_t r;
  aeid_pkg::aeid_dreg_t n;
  logic mem_we;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] byte_in;

  // Command with the detect bit taken out
  function automatic logic [7:0] cmd_base(input logic [7:0] b);
    cmd_base = b & ~`AEID_DET_MASK;
  endfunction

  // Next byte to send: serial number during assignment, else array data
  function automatic logic [7:0] tx_byte(input logic [7:0] c, input logic [2:0] sn,
                                         input logic [7:0] p);
    if (c == `AEID_CMD_ASSIGN && sn < `AEID_SN_BYTES) begin
      tx_byte = SERIAL[8 * (5 - int'(sn)) +: 8];
    end else begin
      tx_byte = mem[p];
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  // Edges and start/stop against the previous sample
  assign scl_rise = bus.scl && !r.scl_q;
  assign scl_fall = !bus.scl && r.scl_q;
  assign start_c = bus.scl && r.scl_q && r.sda_q && !bus.sda;
  assign stop_c = bus.scl && r.scl_q && !r.sda_q && bus.sda;
  assign byte_in = {r.shreg[6:0], bus.sda};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    mem_we = 1'b0;
    n.scl_q = bus.scl;
    n.sda_q = bus.sda;
    // Internal write cycle timer
    if (r.busy) begin
      if (r.cnt == '0) begin
        n.busy = 1'b0;
      end else begin
        n.cnt = r.cnt - 16'h0001;
      end
    end
    case (r.st)
      aeid_pkg::D_RX: begin
        if (scl_rise) begin
          n.shreg = byte_in;
          n.bitcnt = r.bitcnt + 4'h1;
          if (r.bitcnt == 4'h7) begin
            n.st = aeid_pkg::D_ACKW;
            n.ack = 1'b0;
            case (r.idx)
              3'h0: begin
                n.cmd = cmd_base(byte_in);
                n.det_req = byte_in[`AEID_DET_BIT];
                case (cmd_base(byte_in))
                  `AEID_CMD_ASSIGN: n.ack = !r.assigned; // [RL1]
                  `AEID_CMD_CLEAR: n.ack = 1'b1;
                  `AEID_CMD_READ, `AEID_CMD_WRITE: n.ack = r.assigned; // [RL18]
                  default: n.ack = 1'b0;
                endcase
              end
              3'h1: begin
                case (r.cmd)
                  `AEID_CMD_ASSIGN: begin
                    n.ack = !r.assigned; // [RL1]
                    n.pend_id = byte_in;
                    n.sn_idx = 3'h0;
                  end
                  `AEID_CMD_CLEAR: begin
                    n.id = 8'h00; // [RL4]
                    n.assigned = 1'b0; // [RL4]
                    n.ack = 1'b1;
                  end
                  default: begin
                    n.ack = r.assigned && byte_in == r.id && !r.busy; // [RL10] [RL18]
                    // Pin low while the bit is set, seen by the card controller
                    if (n.ack) begin
                      n.det_n = !r.det_req; // [RL6] [RL7]
                    end
                  end
                endcase
              end
              3'h2: begin
                n.ack = r.cmd == `AEID_CMD_WRITE;
                n.ptr = byte_in; // [RL13]
              end
              3'h3: begin
                n.ack = r.cmd == `AEID_CMD_WRITE;
                n.wdata = byte_in;
                n.wr_pend = n.ack;
              end
              default: n.ack = 1'b0;
            endcase
          end
        end
      end
      aeid_pkg::D_ACKW: begin
        if (scl_fall) begin
          n.sda_oe = r.ack;
          n.st = aeid_pkg::D_ACK;
        end
      end
      aeid_pkg::D_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'b0;
          n.bitcnt = 4'h0;
          n.idx = r.idx + 3'h1;
          if (!r.ack) begin
            n.st = aeid_pkg::D_IDLE;
          end else if (r.idx == 3'h1 && (r.cmd == `AEID_CMD_ASSIGN ||
                                         r.cmd == `AEID_CMD_READ)) begin
            n.shreg = tx_byte(r.cmd, r.sn_idx, r.ptr); // [RL2] [RL13]
            n.sda_oe = !n.shreg[7];
            n.st = aeid_pkg::D_TX;
            if (r.cmd == `AEID_CMD_READ) begin
              n.ptr = r.ptr + 8'h01;
            end
          end else begin
            n.st = aeid_pkg::D_RX;
          end
        end
      end
      aeid_pkg::D_TX: begin
        if (scl_rise) begin
          n.bitcnt = r.bitcnt + 4'h1;
          // Released a one but the wire is low: lost the serial arbitration
          if (!r.sda_oe && !bus.sda) begin
            n.st = aeid_pkg::D_IDLE;
          end
        end
        if (scl_fall) begin
          if (r.bitcnt == 4'h8) begin
            n.sda_oe = 1'b0;
            n.st = aeid_pkg::D_TXACK;
          end else begin
            n.shreg = {r.shreg[6:0], 1'b0};
            n.sda_oe = !r.shreg[6];
          end
        end
      end
      aeid_pkg::D_TXACK: begin
        if (scl_rise) begin
          n.ack = !bus.sda;
          if (r.cmd == `AEID_CMD_ASSIGN) begin
            n.sn_idx = r.sn_idx + 3'h1;
            // Last serial byte done: take the offered ID
            if (r.sn_idx == `AEID_SN_BYTES - 3'h1) begin
              n.id = r.pend_id; // [RL2]
              n.assigned = 1'b1; // [RL2]
            end
          end
        end
        if (scl_fall) begin
          n.bitcnt = 4'h0;
          if (r.ack && !(r.cmd == `AEID_CMD_ASSIGN && r.sn_idx == `AEID_SN_BYTES)) begin
            n.shreg = tx_byte(r.cmd, r.sn_idx, r.ptr);
            n.sda_oe = !n.shreg[7];
            n.st = aeid_pkg::D_TX;
            if (r.cmd == `AEID_CMD_READ) begin
              n.ptr = r.ptr + 8'h01;
            end
          end else begin
            n.st = aeid_pkg::D_IDLE;
          end
        end
      end
      default: ;
    endcase
    // Start restarts byte counting; a pending write is dropped
    if (start_c) begin
      n.st = aeid_pkg::D_RX;
      n.idx = 3'h0;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
      n.wr_pend = 1'b0;
    end
    // Stop after a data byte commits it and starts the write cycle
    if (stop_c) begin
      n.st = aeid_pkg::D_IDLE;
      n.sda_oe = 1'b0;
      if (r.wr_pend) begin
        mem_we = 1'b1; // [RL9]
        n.wr_pend = 1'b0;
        n.busy = 1'b1; // [RL9]
        n.cnt = 16'(WRITE_CYCLES - 1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.det_n <= 1'b1;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Array write port
  always_ff @(posedge i_ref_clk) begin
    if (mem_we) begin
      mem[r.ptr] <= r.wdata;
    end
  end

  // Outputs
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = r.sda_oe;
  assign o_card_detect_output_n = r.det_n;
  assign o_assigned = r.assigned;
  assign o_id = r.id;
  assign o_write_busy = r.busy;

endmodule

// *** aeid_checker.sv ***
// Bus-level checks on the two-wire link between master and device ends
`timescale 1ns/1ns
module aeid_checker (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Bus wires and drivers
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // --------------------------------------------------------------
  // Framing conditions
  // --------------------------------------------------------------
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_master_open_drain: assert property ((!m_scl_oe || (!scl && !m_scl_o)) &&
    (!m_sda_oe || (!sda && !m_sda_o))) else $error("master pull does not hold a line low");
  a_dev_open_drain: assert property (d_sda_oe |-> !sda && !d_sda_o)
    else $error("device pull does not hold data line low");
  a_dev_change_low: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  a_start_by_master: assert property (s_start |-> m_sda_oe && !d_sda_oe)
    else $error("start condition not made by master");
  a_stop_by_master: assert property (s_stop |-> !m_sda_oe && !d_sda_oe)
    else $error("device holds data at stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  a_scl_low_max: assert property ($fell(scl) |-> ##[1:40] scl)
    else $error("clock held low too long");
  a_dev_low_bound: assert property ($rose(d_sda_oe) |-> ##[1:160] !d_sda_oe)
    else $error("device holds data low too long");
endmodule

// *** tb.sv ***
// Self-checking bench joining the master and device ends over the link
`timescale 1ns/1ns
`include "aeid_defs.svh"
module tb;
  logic i_ref_clk;
  logic i_rst_n;
  logic i_req;
  aeid_pkg::aeid_op_t i_op;
  logic [7:0] i_id;
  logic [7:0] i_addr;
  logic [7:0] i_data;
  logic i_detect;
  logic o_busy;
  logic o_done;
  logic o_ack;
  logic [7:0] o_rdata;
  logic [7:0] o_last_id;
  logic [7:0] o_stamp_addr;
  aeid_pkg::aeid_card_t o_card;
  logic o_card_detect_output_n;
  logic o_assigned;
  logic [7:0] o_id;
  logic o_write_busy;
  int errors = 0;
  int n_checks = 0;
  int busy_seen = 0;
  logic [7:0] size;

  // ----------------------------------------------------------------
  // Both ends, the link and its checker
  // ----------------------------------------------------------------
  aeid_bus_if bus_i();
  aeid_master #(.QUARTER(4)) aeid_master_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_req(i_req), .i_op(i_op), .i_id(i_id), .i_addr(i_addr), .i_data(i_data),
    .i_detect(i_detect), .o_busy(o_busy), .o_done(o_done), .o_ack(o_ack), .o_rdata(o_rdata),
    .o_last_id(o_last_id), .o_stamp_addr(o_stamp_addr), .o_card(o_card), .bus(bus_i));
  aeid_device #(.SERIAL(48'haaaa_aaaa_aaaa), .WRITE_CYCLES(500)) aeid_device_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus_i), .o_id(o_id),
    .o_card_detect_output_n(o_card_detect_output_n), .o_assigned(o_assigned),
    .o_write_busy(o_write_busy));
  aeid_checker aeid_checker_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .m_scl_o(bus_i.m_scl_o), .m_scl_oe(bus_i.m_scl_oe), .m_sda_o(bus_i.m_sda_o),
    .m_sda_oe(bus_i.m_sda_oe), .d_sda_o(bus_i.d_sda_o), .d_sda_oe(bus_i.d_sda_oe),
    .scl(bus_i.scl), .sda(bus_i.sda));

  // Clock, write-cycle counter and watchdog
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) if (o_write_busy === 1'b1) busy_seen <= busy_seen + 1;
  initial begin
    #600000;
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  function automatic aeid_pkg::aeid_card_t exp_card(input logic [7:0] t);
    case (t)
      `AEID_TYPE_MEMORY: return aeid_pkg::CARD_MEMORY;
      `AEID_TYPE_IO: return aeid_pkg::CARD_IO;
      `AEID_TYPE_DISPLAY: return aeid_pkg::CARD_DISPLAY;
      default: return aeid_pkg::CARD_UNKNOWN;
    endcase
  endfunction
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic do_op(input aeid_pkg::aeid_op_t op, input logic [7:0] id,
      input logic [7:0] a, input logic [7:0] d, input logic det);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_req <= 1'b1;
    i_op <= op;
    i_id <= id;
    i_addr <= a;
    i_data <= d;
    i_detect <= det;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    @(negedge i_ref_clk);
    chk("op_busy", 8'h01, {7'h0, o_busy});
    while (o_done !== 1'b1 && n < 8000) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("op_done", 8'h01, {7'h0, o_done});
    chk("op_idle", 8'h00, {7'h0, o_busy});
  endtask
  // Single-byte write then read back at the same location
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic det);
    int b;
    b = busy_seen;
    do_op(aeid_pkg::OP_WRITE, 8'h01, a, d, det);
    chk("write_ack", 8'h01, {7'h0, o_ack});
    chk("write_cycle_ran", 8'h01, {7'h0, busy_seen > b});
    chk("write_idle", 8'h00, {7'h0, o_write_busy});
    chk("detect_n", {7'h0, ~det}, {7'h0, o_card_detect_output_n});
    do_op(aeid_pkg::OP_READ, 8'h01, a, 8'h00, det);
    chk("read_data", d, o_rdata);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_req = 1'b0;
    i_op = aeid_pkg::OP_CLEAR;
    i_id = 8'h00;
    i_addr = 8'h00;
    i_data = 8'h00;
    i_detect = 1'b0;
    void'($urandom(15561));
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    do_op(aeid_pkg::OP_CLEAR, 8'h00, 8'h00, 8'h00, 1'b0);
    chk("clear_ack", 8'h01, {7'h0, o_ack});
    do_op(aeid_pkg::OP_READ, 8'h01, 8'h00, 8'h00, 1'b0);
    chk("unassigned_ack", 8'h00, {7'h0, o_ack});
    do_op(aeid_pkg::OP_ASSIGN, 8'h00, 8'h00, 8'h00, 1'b0);
    chk("assign_ack", 8'h01, {7'h0, o_ack});
    chk("dev_id", 8'h01, o_id);
    chk("dev_assigned", 8'h01, {7'h0, o_assigned});
    chk("last_id", 8'h01, o_last_id);
    do_op(aeid_pkg::OP_ASSIGN, 8'h00, 8'h00, 8'h00, 1'b0);
    chk("reassign_ack", 8'h00, {7'h0, o_ack});
    chk("last_id_kept", 8'h01, o_last_id);
    size = 8'($urandom_range(3, 255));
    wr_rd(8'h00, size, 1'b1);
    chk("stamp_addr", size - 8'h03, o_stamp_addr);
    for (int t = 0; t < 5; t++) begin
      wr_rd(8'h01, 8'(t), 1'b1);
      chk("card", {6'h0, exp_card(8'(t))}, {6'h0, o_card});
    end
    repeat (6) wr_rd(8'($urandom), 8'($urandom), 1'($urandom));
    do_op(aeid_pkg::OP_READ, 8'h07, 8'h05, 8'h00, 1'b0);
    chk("foreign_id_ack", 8'h00, {7'h0, o_ack});
    do_op(aeid_pkg::OP_CLEAR, 8'h00, 8'h00, 8'h00, 1'b0);
    chk("cleared_assigned", 8'h00, {7'h0, o_assigned});
    chk("cleared_id", 8'h00, o_id);
    chk("cleared_last_id", 8'h00, o_last_id);
    report_and_stop();
  end
endmodule
